// ===== design/pab_bridge.sv
// Port bridge: troubleshooter accesses to emulated controller ports and memory
`timescale 1ns/100ps
`include "pab_params.svh"
// Behaviour
// [RL1] Mode bit 5 picks line 4: latched output or data memory select.
// [RL2] Clearing mode bits 6 or 7 forces data strobe or write low.
// [RL3] Mode bit 4 makes 2006 read actual strobe and write levels.
// [RL4] Port addresses 2000-2007 decode to ports and mode register.
// [RL5] Decode program, data memory and pod RAM ranges.
// [RL6] Host keeps mode bit 4 low for ordinary port 0/3 access.
// [RL7] Reading a port 0 nibble makes it input and returns levels.
// [RL8] Writing a port 0 nibble makes it output and latches data.
// [RL9] First read after output-to-input may be wrong; read again.
// [RL10] Mode bit 4 makes port 0 reads return actual pin levels.
// [RL11] Port 3 low nibble input only, high nibble output only.
// [RL12] Wide port write drives all lines; read keeps drivers on.
// [RL13] External memory read turns wide port drivers off.
// [RL14] External access removes latched wide port data.
// [RL15] Per-line port: writes output, reads levels, inputs need a 1.
// [RL16] Program memory is read only; data memory reads and writes.
// [RL17] Only low eight address bits go out on memory cycles.
// [RL18] Host preloads upper address through port 0 nibbles.
// [RL19] Memory cycles multiplex address and data with two strobes.
// [RL20] Select low and write low only in the data transfer.
// [RL21] Serial input drives status bit 2 and input nibble bit 0.
// [RL22] Host does not write port 0/3 while mode bit 4 is set.
// [RL23] Mode bit 4 keeps outputs driven and reads actual levels.
// [RL24] Readback puts strobe at bit 0, write at bit 1, rest zero.
// [RL25] Exactly one data strobe pulse per memory transfer.
module pab_bridge #(
  parameter int PHASE_CYC = `PAB_PHASE_CYC,
  parameter int RAM_DEPTH = 256
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic o_ack,
  output logic [7:0] o_rdata,
  output logic [7:0] o_status,
  input wire logic [7:0] i_wide_in,
  output logic [7:0] o_wide_out,
  output logic o_wide_oe,
  input wire logic [7:0] i_line_in,
  output logic [7:0] o_line_out,
  output logic [7:0] o_line_oe,
  input wire logic [7:0] i_upper_in,
  output logic [7:0] o_upper_out,
  output logic [1:0] o_upper_oe,
  input wire logic [3:0] i_input_nibble_lines,
  input wire logic [3:0] i_output_nibble_sense,
  output logic [3:0] o_output_nibble_lines,
  input wire logic i_data_strobe_sense,
  input wire logic i_write_sense,
  output logic o_address_strobe_n,
  output logic o_data_strobe_n,
  output logic o_write_n
);
  import pab_pkg::*;
  logic [7:0] wide_s;
  logic [7:0] line_s;
  logic [7:0] upper_s;
  logic [3:0] innib_s;
  logic [3:0] outsense_s;
  logic [1:0] ctl_s;
  logic [7:0] mode_r;
  logic [7:0] wide_r;
  logic [7:0] line_r;
  logic [7:0] upper_r;
  logic [1:0] upper_dir_r;
  logic [3:0] outnib_r;
  logic wide_drive_r;
  logic [7:0] ram_mem [RAM_DEPTH];
  logic mc_start_r;
  logic mc_busy;
  logic mc_done;
  logic [7:0] mc_rdata;
  logic [7:0] mc_bus;
  logic mc_bus_oe;
  logic mc_as_n;
  logic mc_ds_n;
  logic mc_wr_n;
  logic mc_dm_n;
  logic pending_r;
  logic hit_prog;
  logic hit_data;
  logic hit_ram;
  logic hit_mem;
  logic readback;
  logic [7:0] rd_nxt;
  logic take;

  pab_sync #(.WIDTH(8)) u_sync_wide (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_async(i_wide_in), .o_sync(wide_s));
  pab_sync #(.WIDTH(8)) u_sync_line (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_async(i_line_in), .o_sync(line_s));
  pab_sync #(.WIDTH(8)) u_sync_upper (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_async(i_upper_in), .o_sync(upper_s));
  pab_sync #(.WIDTH(10)) u_sync_misc (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_async({i_write_sense, i_data_strobe_sense, i_output_nibble_sense,
      i_input_nibble_lines}),
    .o_sync({ctl_s, outsense_s, innib_s}));

  pab_mem_cycle #(.PHASE_CYC(PHASE_CYC)) u_mem (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_start(mc_start_r),
    .i_write(i_we),
    .i_data_space(hit_data),
    .i_low_addr(i_addr[7:0]),
    .i_wdata(i_wdata),
    .i_bus_in(wide_s),
    .o_busy(mc_busy),
    .o_done(mc_done),
    .o_rdata(mc_rdata),
    .o_bus_out(mc_bus),
    .o_bus_oe(mc_bus_oe),
    .o_address_strobe_n(mc_as_n),
    .o_data_strobe_n(mc_ds_n),
    .o_write_n(mc_wr_n),
    .o_data_memory_select_n(mc_dm_n)
  );

  // [RL5] Address range decode
  always_comb begin
    hit_prog = (i_addr >= `PAB_PROG_LO) && (i_addr <= `PAB_PROG_HI);
    hit_data = (i_addr >= `PAB_DATA_LO) && (i_addr <= `PAB_DATA_HI);
    hit_ram = (i_addr >= `PAB_RAM_LO) && (i_addr <= `PAB_RAM_HI);
    // [RL16] Program memory writes ignored
    hit_mem = hit_data || (hit_prog && !i_we);
    readback = mode_r[`PAB_MODE_READBACK];
    take = i_req && !pending_r && !o_ack;
  end

  // [RL4] Register read decode
  always_comb begin
    rd_nxt = 8'h00;
    if (i_addr == `PAB_ADDR_WIDE_PORT) begin
      // [RL12] Read keeps drivers on
      rd_nxt = wide_s;
    end else if (i_addr == `PAB_ADDR_LINE_PORT) begin
      // [RL15] Read line levels
      rd_nxt = line_s;
    end else if (i_addr == `PAB_ADDR_MODE) begin
      rd_nxt = mode_r;
    end else if (i_addr == `PAB_ADDR_UPPER_LO) begin
      // [RL10] Sensed levels either way
      rd_nxt = {4'h0, upper_s[3:0]};
    end else if (i_addr == `PAB_ADDR_UPPER_HI) begin
      rd_nxt = {4'h0, upper_s[7:4]};
    end else if (i_addr == `PAB_ADDR_IN_NIB) begin
      // [RL3] Drivability of strobe lines
      if (readback) begin
        // [RL24] Strobe and write levels
        rd_nxt[`PAB_RB_DS_BIT] = ctl_s[0];
        rd_nxt[`PAB_RB_RW_BIT] = ctl_s[1];
      end else begin
        // [RL21] Serial line in bit 0
        rd_nxt = {4'h0, innib_s};
      end
    end else if (i_addr == `PAB_ADDR_OUT_NIB) begin
      // [RL11] Readback of output nibble
      rd_nxt = readback ? {4'h0, outsense_s} : {4'h0, outnib_r};
    end else if (hit_ram) begin
      rd_nxt = ram_mem[i_addr[7:0]];
    end
  end

  // Request handshake; memory cycles answer on completion
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_ack <= 1'b0;
      o_rdata <= 8'h00;
      pending_r <= 1'b0;
      mc_start_r <= 1'b0;
    end else begin
      o_ack <= 1'b0;
      mc_start_r <= 1'b0;
      if (pending_r) begin
        if (mc_done) begin
          pending_r <= 1'b0;
          o_ack <= 1'b1;
          o_rdata <= i_we ? 8'h00 : mc_rdata;
        end
      end else if (take && hit_mem) begin
        pending_r <= 1'b1;
        mc_start_r <= 1'b1;
      end else if (take) begin
        o_ack <= 1'b1;
        o_rdata <= i_we ? 8'h00 : rd_nxt;
      end
    end
  end

  // Mode register and port latches
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mode_r <= `PAB_MODE_RESET;
      line_r <= `PAB_LINE_PORT_RESET;
      upper_r <= 8'h00;
      upper_dir_r <= 2'b00;
      outnib_r <= 4'h0;
    end else if (take && i_we) begin
      if (i_addr == `PAB_ADDR_MODE) begin
        mode_r <= i_wdata;
      end else if (i_addr == `PAB_ADDR_LINE_PORT) begin
        // [RL15] Per-line output data
        line_r <= i_wdata;
      end else if (i_addr == `PAB_ADDR_UPPER_LO && !readback) begin
        // [RL8] Low nibble becomes output
        upper_r[3:0] <= i_wdata[3:0];
        upper_dir_r[0] <= 1'b1;
      end else if (i_addr == `PAB_ADDR_UPPER_HI && !readback) begin
        upper_r[7:4] <= i_wdata[3:0];
        upper_dir_r[1] <= 1'b1;
      end else if (i_addr == `PAB_ADDR_OUT_NIB && !readback) begin
        // [RL1] Latched output nibble
        outnib_r <= i_wdata[3:0];
      end
    end else if (take && !readback) begin
      // [RL9] First read only switches
      // [RL7] Read turns nibble to input
      if (i_addr == `PAB_ADDR_UPPER_LO) begin
        upper_dir_r[0] <= 1'b0;
      end else if (i_addr == `PAB_ADDR_UPPER_HI) begin
        upper_dir_r[1] <= 1'b0;
      end
    end
  end

  // Wide port latch and drive control
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wide_r <= 8'h00;
      wide_drive_r <= 1'b0;
    end else if (take && i_we && i_addr == `PAB_ADDR_WIDE_PORT) begin
      // [RL12] Write drives all lines
      wide_r <= i_wdata;
      wide_drive_r <= 1'b1;
    end else if (take && hit_mem) begin
      // [RL13] Memory access drops drivers
      wide_drive_r <= 1'b0;
      // [RL14] Latched data cleared
      wide_r <= 8'h00;
    end
  end

  always_ff @(posedge i_clk) begin
    if (take && i_we && hit_ram) begin
      ram_mem[i_addr[7:0]] <= i_wdata;
    end
  end

  // Registered pin drive
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_wide_out <= 8'h00;
      o_wide_oe <= 1'b0;
      o_line_out <= 8'hff;
      o_line_oe <= 8'h00;
      o_upper_out <= 8'h00;
      o_upper_oe <= 2'b00;
      o_output_nibble_lines <= 4'hf;
      o_address_strobe_n <= 1'b1;
      o_data_strobe_n <= 1'b1;
      o_write_n <= 1'b1;
      o_status <= 8'h00;
    end else begin
      // [RL19] Bus muxed during cycles
      // Done cycle already shows the cleared latch, not the old address
      o_wide_out <= (mc_busy && !mc_done) ? mc_bus : wide_r;
      o_wide_oe <= (mc_busy && !mc_done) ? mc_bus_oe : wide_drive_r;
      // [RL15] Lines holding 1 released
      o_line_out <= line_r;
      o_line_oe <= ~line_r;
      // [RL23] Outputs held during readback
      o_upper_out <= upper_r;
      o_upper_oe <= upper_dir_r;
      // [RL1] Line 4 role by mode bit
      o_output_nibble_lines <= {outnib_r[3:1],
        mode_r[`PAB_MODE_SELECT_ROLE] ? mc_dm_n : outnib_r[0]};
      o_address_strobe_n <= mc_as_n;
      // [RL2] Mode bits force lines low
      o_data_strobe_n <= mc_ds_n & mode_r[`PAB_MODE_DS_RELEASE];
      o_write_n <= mc_wr_n & mode_r[`PAB_MODE_RW_RELEASE];
      // [RL21] Serial level in status
      o_status <= {5'h00, innib_s[0], 2'b00};
    end
  end
endmodule

// ===== design/pab_params.svh
// Address map, mode bits and timing counts of the port bridge
`ifndef PAB_PARAMS_SVH
`define PAB_PARAMS_SVH
`define PAB_ADDR_WIDE_PORT 16'h2000
`define PAB_ADDR_LINE_PORT 16'h2001
`define PAB_ADDR_MODE 16'h2002
`define PAB_ADDR_UPPER_LO 16'h2004
`define PAB_ADDR_UPPER_HI 16'h2005
`define PAB_ADDR_IN_NIB 16'h2006
`define PAB_ADDR_OUT_NIB 16'h2007
`define PAB_PROG_LO 16'h0000
`define PAB_PROG_HI 16'h0fff
`define PAB_DATA_LO 16'h1100
`define PAB_DATA_HI 16'h11ff
`define PAB_RAM_LO 16'h3000
`define PAB_RAM_HI 16'h30ff
`define PAB_MODE_READBACK 4
`define PAB_MODE_SELECT_ROLE 5
`define PAB_MODE_DS_RELEASE 6
`define PAB_MODE_RW_RELEASE 7
`define PAB_MODE_RESET 8'hc0
`define PAB_LINE_PORT_RESET 8'hff
`define PAB_RB_DS_BIT 0
`define PAB_RB_RW_BIT 1
`define PAB_STS_SERIAL_BIT 2
`define PAB_PHASE_NS 100
`define PAB_PHASE_CYC ((`PAB_PHASE_NS + 9) / 10)
`endif

// ===== design/pab_pkg.sv
// Types shared by the port bridge modules
package pab_pkg;
  typedef enum logic [2:0] {
    PAB_IDLE = 3'b000,
    PAB_ADDR = 3'b001,
    PAB_LATCH = 3'b010,
    PAB_DATA = 3'b011,
    PAB_DONE = 3'b100
  } pab_state_type;
endpackage

// ===== design/pab_sync.sv
// Two flip-flop synchroniser for a bus of pin levels
`timescale 1ns/100ps
module pab_sync #(
  parameter int WIDTH = 8
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_r;
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      meta_r <= '0;
      o_sync <= '0;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule

// ===== design/pab_mem_cycle.sv
// Multiplexed external memory cycle sequencer
`timescale 1ns/100ps
`include "pab_params.svh"
module pab_mem_cycle #(
  parameter int PHASE_CYC = `PAB_PHASE_CYC
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_start,
  input wire logic i_write,
  input wire logic i_data_space,
  input wire logic [7:0] i_low_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] i_bus_in,
  output logic o_busy,
  output logic o_done,
  output logic [7:0] o_rdata,
  output logic [7:0] o_bus_out,
  output logic o_bus_oe,
  output logic o_address_strobe_n,
  output logic o_data_strobe_n,
  output logic o_write_n,
  output logic o_data_memory_select_n
);
  import pab_pkg::*;
  pab_state_type state_r;
  logic [7:0] cnt_r;
  logic wr_r;
  logic dsp_r;
  logic [7:0] wd_r;
  logic phase_end;
  assign phase_end = (cnt_r == 8'(PHASE_CYC - 1));

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_r <= PAB_IDLE;
      cnt_r <= 8'h00;
      wr_r <= 1'b0;
      dsp_r <= 1'b0;
      wd_r <= 8'h00;
      o_rdata <= 8'h00;
    end else begin
      cnt_r <= (state_r == PAB_IDLE || phase_end) ? 8'h00 : cnt_r + 8'h01;
      case (state_r)
        PAB_IDLE: begin
          if (i_start) begin
            state_r <= PAB_ADDR;
            wr_r <= i_write;
            dsp_r <= i_data_space;
            wd_r <= i_wdata;
          end
        end
        PAB_ADDR: begin
          if (phase_end) begin
            state_r <= PAB_LATCH;
          end
        end
        PAB_LATCH: begin
          if (phase_end) begin
            state_r <= PAB_DATA;
          end
        end
        PAB_DATA: begin
          // Pins lag three cycles, so phases under 4 capture stale data
          if (phase_end) begin
            state_r <= PAB_DONE;
            o_rdata <= i_bus_in;
          end
        end
        default: begin
          state_r <= PAB_IDLE;
        end
      endcase
    end
  end

  // [RL19] Address then data on bus
  always_comb begin
    o_busy = (state_r != PAB_IDLE);
    o_done = (state_r == PAB_DONE);
    o_address_strobe_n = ~(state_r == PAB_ADDR);
    // [RL25] One data strobe pulse
    o_data_strobe_n = ~(state_r == PAB_DATA);
    // [RL20] Select and write in strobe
    o_write_n = ~(state_r == PAB_DATA && wr_r);
    o_data_memory_select_n = ~(state_r == PAB_DATA && dsp_r);
    // [RL17] Low address byte only
    o_bus_out = (state_r == PAB_DATA) ? wd_r : i_low_addr;
    o_bus_oe = (state_r == PAB_ADDR) || (state_r == PAB_LATCH)
      || (state_r == PAB_DATA && wr_r);
  end
endmodule

// ===== tb/pab_bridge_monitor.sv
// Concurrent checks on the port bridge top-level ports
`timescale 1ns/100ps
module pab_bridge_monitor #(
  parameter int PHASE_CYC = 10,
  parameter int RAM_DEPTH = 256
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic o_ack,
  input wire logic [7:0] o_rdata,
  input wire logic [7:0] o_status,
  input wire logic [7:0] i_wide_in,
  input wire logic [7:0] o_wide_out,
  input wire logic o_wide_oe,
  input wire logic [7:0] i_line_in,
  input wire logic [7:0] o_line_out,
  input wire logic [7:0] o_line_oe,
  input wire logic [7:0] i_upper_in,
  input wire logic [7:0] o_upper_out,
  input wire logic [1:0] o_upper_oe,
  input wire logic [3:0] i_input_nibble_lines,
  input wire logic [3:0] i_output_nibble_sense,
  input wire logic [3:0] o_output_nibble_lines,
  input wire logic i_data_strobe_sense,
  input wire logic i_write_sense,
  input wire logic o_address_strobe_n,
  input wire logic o_data_strobe_n,
  input wire logic o_write_n
);
  localparam int MEM_LAT = 3 * PHASE_CYC + 3;
  logic [7:0] mode_r, as_cnt, ds_cnt;
  logic [2:0] ser_cnt;
  logic req_d, busy_r, dsp_r, ser_d, quiet, mem_a;
  assign mem_a = (i_addr <= 16'h0fff && !i_we) || (i_addr >= 16'h1100 && i_addr <= 16'h11ff);
  // Mode copy lags the design, so checks wait for a quiet bus
  assign quiet = !i_req && !req_d;
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mode_r <= 8'hc0;
      {as_cnt, ds_cnt, ser_cnt} <= '0;
      {req_d, busy_r, dsp_r, ser_d} <= '0;
    end else begin
      req_d <= i_req;
      if (o_ack && i_req && i_we && i_addr == 16'h2002) begin
        mode_r <= i_wdata;
      end
      if (o_ack) begin
        busy_r <= 1'b0;
      end else if (i_req && mem_a) begin
        busy_r <= 1'b1;
        dsp_r <= i_addr[12];
      end
      as_cnt <= o_address_strobe_n ? 8'h00 : as_cnt + 8'h01;
      ds_cnt <= o_data_strobe_n ? 8'h00 : ds_cnt + 8'h01;
      ser_d <= i_input_nibble_lines[0];
      if (i_input_nibble_lines[0] != ser_d) begin
        ser_cnt <= 3'h0;
      end else if (ser_cnt != 3'h7) begin
        ser_cnt <= ser_cnt + 3'h1;
      end
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sequence addr_done;
    $rose(o_address_strobe_n) ##0 (as_cnt == PHASE_CYC);
  endsequence
  sequence data_pulse;
    $fell(o_data_strobe_n) ##PHASE_CYC ($rose(o_data_strobe_n) && ds_cnt == PHASE_CYC);
  endsequence
  reg_ack_a: assert property ($rose(i_req) && !mem_a |=> o_ack)
    else $error("register access not answered next cycle");
  mem_ack_a: assert property ($rose(i_req) && mem_a |-> ##MEM_LAT o_ack)
    else $error("memory access answer late or missing");
  addr_out_a: assert property (!o_address_strobe_n |-> o_wide_oe && o_wide_out == i_addr[7:0])
    else $error("low address not on bus during address strobe");
  mem_order_a: assert property ((busy_r && mode_r[6]) ##0 addr_done |-> ##PHASE_CYC data_pulse)
    else $error("data strobe pulse wrong after address strobe");
  strobe_rest_a: assert property (
    quiet |-> o_address_strobe_n && o_data_strobe_n == mode_r[6] && o_write_n == mode_r[7])
    else $error("idle strobe levels disagree with mode");
  select_idle_a: assert property (quiet && mode_r[5] |-> o_output_nibble_lines[0])
    else $error("memory select not idle high");
  select_data_a: assert property (
    busy_r && dsp_r && mode_r[5] && !o_data_strobe_n |-> !o_output_nibble_lines[0])
    else $error("memory select not low in data transfer");
  write_ds_a: assert property (!o_write_n && mode_r[7] |-> !o_data_strobe_n && busy_r && dsp_r)
    else $error("write low outside a data write transfer");
  wide_clear_a: assert property (o_ack && busy_r |-> !o_wide_oe && o_wide_out == 8'h00)
    else $error("wide port latch kept after memory access");
  serial_sts_a: assert property (ser_cnt == 3'h7 |-> o_status == {5'h00, ser_d, 2'b00})
    else $error("status does not follow serial input");
endmodule
bind pab_bridge pab_bridge_monitor #(.PHASE_CYC(PHASE_CYC), .RAM_DEPTH(RAM_DEPTH)) mon (.*);

// ===== tb/pab_uut_mem.sv
// Board under test: external memory on the multiplexed bus
`timescale 1ns/100ps
module pab_uut_mem (
  input wire logic i_clk,
  input wire logic [7:0] i_bus,
  input wire logic [7:0] i_upper,
  input wire logic i_as_n,
  input wire logic i_ds_n,
  input wire logic i_w_n,
  input wire logic [3:0] i_lag,
  output logic [7:0] o_drv,
  output logic o_en
);
  logic [7:0] mem [0:4095];
  logic [11:0] addr_r = 12'h000;
  logic [3:0] cnt_r = 4'h0;
  always @(posedge i_clk) begin
    // page from upper port, byte from bus
    if (!i_as_n) begin
      addr_r <= {i_upper[3:0], i_bus};
    end
    cnt_r <= i_ds_n ? 4'h0 : cnt_r + 4'h1;
    // store only in a write transfer
    if (!i_ds_n && !i_w_n) begin
      mem[addr_r] <= i_bus;
    end
  end
  // answer in the strobe, late by i_lag to mimic slow parts
  assign o_en = !i_ds_n && i_w_n && (cnt_r >= i_lag);
  assign o_drv = mem[addr_r];
endmodule

// ===== tb/tb.sv
// Self-checking bench for the port bridge
`timescale 1ns/100ps
module tb;
  logic i_clk = 0;
  logic i_sys_rst = 1;
  logic i_req = 0;
  logic i_we = 0;
  logic [15:0] i_addr = 0;
  logic [7:0] i_wdata = 0;
  logic [7:0] rd, o_rdata, o_status, wo, wi, lo, loe, uo, ui, md;
  logic [7:0] flt_r = 0;
  logic [3:0] nib = 4'h6;
  logic [3:0] stuck = 0;
  logic [3:0] lag = 0;
  logic [3:0] onl;
  logic [1:0] uoe;
  logic o_ack, woe, as_n, ds_n, w_n, men;
  int n_fail = 0;
  int compares = 0;
  always #5 i_clk = ~i_clk;
  // Released bus shows the inverse of its last level
  assign wi = woe ? wo : men ? md : flt_r;
  always @(posedge i_clk) flt_r <= ~wi;
  assign ui = {uoe[1] ? uo[7:4] ^ stuck : 4'h9, uoe[0] ? uo[3:0] : 4'ha};
  pab_bridge #(.PHASE_CYC(6)) dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req(i_req),
    .i_we(i_we), .i_addr(i_addr), .i_wdata(i_wdata), .o_ack(o_ack), .o_rdata(o_rdata),
    .o_status(o_status), .i_wide_in(wi), .o_wide_out(wo), .o_wide_oe(woe),
    .i_line_in((lo & loe) | (8'ha5 & ~loe)), .o_line_out(lo), .o_line_oe(loe),
    .i_upper_in(ui), .o_upper_out(uo), .o_upper_oe(uoe), .i_input_nibble_lines(nib),
    .i_output_nibble_sense(onl ^ stuck), .o_output_nibble_lines(onl),
    .i_data_strobe_sense(ds_n), .i_write_sense(w_n), .o_address_strobe_n(as_n),
    .o_data_strobe_n(ds_n), .o_write_n(w_n));
  pab_uut_mem uut (.i_clk(i_clk), .i_bus(wi), .i_upper(ui), .i_as_n(as_n), .i_ds_n(ds_n),
    .i_w_n(w_n), .i_lag(lag), .o_drv(md), .o_en(men));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic we, input logic [15:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge i_clk);
    i_req <= 1'b1;
    i_we <= we;
    i_addr <= a;
    i_wdata <= d;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_ack !== 1'b1 && n < 100);
    rd = o_rdata;
    i_req <= 1'b0;
    if (n >= 100) chk(8'h00, 8'h01);
  endtask
  // Pins need three extra cycles to reach reads
  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    repeat (3) @(posedge i_clk);
    acc(1'b0, a, 8'h00);
    chk(rd, e);
  endtask
  task automatic t_regs;
    rdc(16'h2002, 8'hc0);
    acc(1'b1, 16'h30ff, 8'h5e);
    rdc(16'h30ff, 8'h5e);
    rdc(16'h2003, 8'h00);
    rdc(16'h1000, 8'h00);
    acc(1'b1, 16'h2001, 8'h0f);
    rdc(16'h2001, 8'h05);
  endtask
  task automatic t_wide;
    acc(1'b1, 16'h2000, 8'h3c);
    rdc(16'h2000, 8'h3c);
    chk({7'h0, woe}, 8'h01);
  endtask
  task automatic t_port0;
    acc(1'b1, 16'h2004, 8'h03);
    acc(1'b1, 16'h2005, 8'h0c);
    @(posedge i_clk);
    chk(uo, 8'hc3);
    acc(1'b0, 16'h2004, 8'h00);
    rdc(16'h2004, 8'h0a);
    chk({6'h0, uoe}, 8'h02);
  endtask
  task automatic t_readback;
    acc(1'b1, 16'h2007, 8'h0a);
    @(posedge i_clk);
    chk({4'h0, onl}, 8'h0a);
    rdc(16'h2006, 8'h07);
    stuck <= 4'h4;
    acc(1'b1, 16'h2002, 8'hd0);
    rdc(16'h2005, 8'h08);
    rdc(16'h2007, 8'h0e);
    rdc(16'h2006, 8'h03);
    acc(1'b1, 16'h2002, 8'h10);
    rdc(16'h2006, 8'h00);
    acc(1'b1, 16'h2002, 8'hc0);
  endtask
  task automatic t_mem;
    acc(1'b1, 16'h2002, 8'he0);
    acc(1'b1, 16'h2004, 8'h07);
    acc(1'b1, 16'h2000, 8'h55);
    acc(1'b1, 16'h11ca, 8'h3b);
    chk(wo, 8'h00);
    lag <= 4'h1;
    acc(1'b1, 16'h2000, 8'h99);
    rdc(16'h01ca, 8'h3b);
    chk({7'h0, woe}, 8'h00);
    acc(1'b1, 16'h00ca, 8'h77);
    rdc(16'h11ca, 8'h3b);
  endtask
  task automatic final_report;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge i_clk);
    n_fail++;
    final_report;
  end
  initial begin
    repeat (3) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    nib <= 4'h7;
    chk({5'h0, as_n, ds_n, w_n}, 8'h07);
    chk(lo, 8'hff);
    t_regs;
    t_wide;
    t_port0;
    t_readback;
    t_mem;
    chk(o_status, 8'h04);
    final_report;
  end
endmodule
